/* bcd_hold_defs.vh */
// Constants for the BCD result port and measurement hold block
`ifndef BCD_HOLD_DEFS_VH
`define BCD_HOLD_DEFS_VH
// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 250
`define T_SET_MS 7'h1E
`define T_VALID_MS 7'h28
`define T_TAIL_MS 7'h10
`define T_PERIOD_MS 7'h40
`define T_REARM_MS (`T_PERIOD_MS - `T_VALID_MS - `T_TAIL_MS)
`define MS_CYCLES (`CLK_MHZ * 1000)
// ****************************************
// Register byte offsets
// ****************************************
`define A_CTRL 8'h00
`define A_OFFSET 8'h04
`define A_HI 8'h08
`define A_LO 8'h0C
`define A_TEACH 8'h10
`define A_STATUS 8'h14
`define A_VALUE 8'h18
// ****************************************
// Control fields
// ****************************************
`define F_MODE_LSB 0
`define F_STBY 3
`define F_SLOPE 4
`define F_SIGN 5
`define F_TEACH 6
`define F_CLEAR 7
`define MODE_NORMAL 3'h0
`define MODE_PEAK 3'h1
`define MODE_BOTTOM 3'h2
`define MODE_SAMPLE 3'h3
`define MODE_P2P 3'h4
// ****************************************
// Reset values and BCD clamp limit
// ****************************************
`define CTRL_RST 6'h00
`define OFFSET_RST 20'h00000
`define HI_RST 20'h7FFFF
`define LO_RST 20'h80000
`define BCD_MAX 20'h1869F
`endif

/* bcd_result_port.v */
// BCD result port with measurement hold, scaling and comparison
`timescale 1ns/10ps
`include "bcd_hold_defs.vh"
// Contract
// - Single transfer: word and qualifier appear 30 ms after demand rising edge.
// - Qualifier drops 40 ms after rising; data released 16 ms later.
// - While demand stays high, a fresh word is emitted every 64 ms.
// - Freeze during word change yields old or new word intact, never zeros.
// - Normal mode measures continuously; comparison follows every new result.
// - Peak or bottom hold keeps the largest or smallest value of the period.
// - Sampling hold latches the value on each sample strobe rising edge.
// - Peak-to-peak hold keeps maximum minus minimum over the period.
// - Standby keeps comparison outputs off until value first enters pass range.
// - Readings are scaled with offset shift, slope inversion and sign reversal.
// - Teach command captures the present value into a register that is only read back at A_TEACH.
// - Reset input restarts tracking; maximum and minimum are reloaded from the next measurement.
module bcd_result_port #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input wire clock,
    input wire rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire meas_valid,
    input wire [19:0] meas_data,
    input wire read_req_in,
    input wire sample_in,
    input wire freeze_in,
    input wire clear_in,
    input wire startup_delay_input,
    output reg [19:0] bcd_digits_q,
    output reg bcd_sign_q,
    output reg bcd_oe_q,
    output reg data_valid_q,
    output reg cmp_hi_q,
    output reg cmp_pass_q,
    output reg cmp_lo_q
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SET = 3'h1;
    localparam ST_VALID = 3'h2;
    localparam ST_TAIL = 3'h3;
    localparam ST_REARM = 3'h4;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg req_prev_q;
    reg samp_prev_q;
    reg clr_prev_q;
    wire req_s = sync2_q[0];
    wire samp_s = sync2_q[1];
    wire frz_s = sync2_q[2];
    wire clr_s = sync2_q[3];
    wire stdly_s = sync2_q[4];

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            req_prev_q <= 1'b0;
            samp_prev_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end else begin
            sync1_q <= {startup_delay_input, clear_in, freeze_in, sample_in, read_req_in};
            sync2_q <= sync1_q;
            req_prev_q <= req_s;
            samp_prev_q <= samp_s;
            clr_prev_q <= clr_s;
        end
    end

    wire req_rise = req_s & ~req_prev_q;
    wire samp_rise = samp_s & ~samp_prev_q;
    wire clr_rise = clr_s & ~clr_prev_q;

    // ****************************************
    // APB registers
    // ****************************************
    reg [5:0] ctrl_q;
    reg [19:0] offset_q;
    reg [19:0] hi_q;
    reg [19:0] lo_q;
    reg [19:0] teach_q;
    wire acc = psel & penable;
    wire hit = (paddr == `A_CTRL) | (paddr == `A_OFFSET) | (paddr == `A_HI) |
               (paddr == `A_LO) | (paddr == `A_TEACH) | (paddr == `A_STATUS) |
               (paddr == `A_VALUE);
    wire wr = acc & pwrite & hit;
    wire wr_ctrl = wr & (paddr == `A_CTRL);
    wire teach_cmd = wr_ctrl & pwdata[`F_TEACH];
    wire restart = clr_rise | (wr_ctrl & pwdata[`F_CLEAR]);
    wire [2:0] mode = ctrl_q[`F_MODE_LSB +: 3];
    wire stby_en = ctrl_q[`F_STBY];

    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    // ****************************************
    // Scaling
    // ****************************************
    reg [19:0] cur_q;
    wire [19:0] slope_v = ctrl_q[`F_SLOPE] ? (20'h00000 - meas_data) : meas_data;
    wire [19:0] shift_v = slope_v + offset_q;
    wire [19:0] scaled = ctrl_q[`F_SIGN] ? (20'h00000 - shift_v) : shift_v;
    // Startup delay input suspends measurement while it is asserted
    wire new_meas = meas_valid & ~stdly_s;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RST;
            offset_q <= `OFFSET_RST;
            hi_q <= `HI_RST;
            lo_q <= `LO_RST;
            teach_q <= 20'h00000;
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata[5:0];
            if (wr & (paddr == `A_OFFSET)) offset_q <= pwdata[19:0];
            if (wr & (paddr == `A_HI)) hi_q <= pwdata[19:0];
            if (wr & (paddr == `A_LO)) lo_q <= pwdata[19:0];
            if (teach_cmd) teach_q <= cur_q;
        end
    end

    // ****************************************
    // Hold modes
    // ****************************************
    reg [19:0] max_q;
    reg [19:0] min_q;
    reg [19:0] samp_q;
    reg track_q;
    reg [19:0] held;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cur_q <= 20'h00000;
            max_q <= 20'h00000;
            min_q <= 20'h00000;
            samp_q <= 20'h00000;
            track_q <= 1'b0;
        end else begin
            if (new_meas) cur_q <= scaled;
            if (samp_rise) samp_q <= cur_q;
            if (new_meas) begin
                track_q <= 1'b1;
                if (restart || !track_q || $signed(scaled) > $signed(max_q)) max_q <= scaled;
                if (restart || !track_q || $signed(scaled) < $signed(min_q)) min_q <= scaled;
            end else if (restart) begin
                track_q <= 1'b0;
            end
        end
    end

    always @* begin
        case (mode)
            `MODE_NORMAL: held = cur_q;
            `MODE_PEAK: held = max_q;
            `MODE_BOTTOM: held = min_q;
            `MODE_SAMPLE: held = samp_q;
            `MODE_P2P: held = max_q - min_q;
            default: held = cur_q;
        endcase
    end

    // ****************************************
    // Comparison and standby
    // ****************************************
    reg armed_q;
    reg stby_prev_q;
    wire in_hi = $signed(held) > $signed(hi_q);
    wire in_lo = $signed(held) < $signed(lo_q);
    wire in_pass = ~in_hi & ~in_lo;
    wire gate = stby_en & (armed_q | ~stby_prev_q) & ~in_pass;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b1;
            stby_prev_q <= 1'b0;
            cmp_hi_q <= 1'b0;
            cmp_pass_q <= 1'b0;
            cmp_lo_q <= 1'b0;
        end else begin
            stby_prev_q <= stby_en;
            // Enabling standby re-arms it so the sequence starts afresh
            if (stby_en & ~stby_prev_q) armed_q <= 1'b1;
            else if (in_pass) armed_q <= 1'b0;
            cmp_hi_q <= in_hi & ~gate;
            cmp_pass_q <= in_pass;
            cmp_lo_q <= in_lo & ~gate;
        end
    end

    // ****************************************
    // Frozen source and BCD conversion
    // ****************************************
    reg [19:0] src_q;
    // Freeze only stops the source; a word is always loaded whole in one cycle
    always @(posedge clock or posedge rst) begin
        if (rst) src_q <= 20'h00000;
        else if (!frz_s) src_q <= held;
    end

    function [19:0] to_bcd;
        input [19:0] v;
        integer i;
        integer k;
        reg [19:0] b;
        reg [19:0] m;
        begin
            b = 20'h00000;
            m = (v > `BCD_MAX) ? `BCD_MAX : v;
            for (i = 0; i < 20; i = i + 1) begin
                for (k = 0; k < 5; k = k + 1) begin
                    if (b[4*k +: 4] > 4'h4) b[4*k +: 4] = b[4*k +: 4] + 4'h3;
                end
                b = {b[18:0], m[19 - i]};
            end
            to_bcd = b;
        end
    endfunction

    wire [19:0] mag = src_q[19] ? (20'h00000 - src_q) : src_q;
    wire [19:0] word_bcd = to_bcd(mag);

    // ****************************************
    // Millisecond timer and transfer sequence
    // ****************************************
    reg [17:0] div_q;
    reg [6:0] ph_q;
    reg [2:0] st_q;
    reg [6:0] target;
    wire ms_tick = (div_q == MS_CYCLES - 1);
    wire ph_done = ms_tick & (ph_q == target - 7'h01);

    always @* begin
        case (st_q)
            ST_SET: target = `T_SET_MS;
            ST_VALID: target = `T_VALID_MS;
            ST_TAIL: target = `T_TAIL_MS;
            ST_REARM: target = `T_REARM_MS;
            default: target = 7'h01;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 18'h00000;
            ph_q <= 7'h00;
            st_q <= ST_IDLE;
            bcd_digits_q <= 20'h00000;
            bcd_sign_q <= 1'b0;
            bcd_oe_q <= 1'b0;
            data_valid_q <= 1'b0;
        end else begin
            div_q <= ms_tick ? 18'h00000 : div_q + 18'h00001;
            if (ms_tick) ph_q <= ph_q + 7'h01;
            case (st_q)
                ST_IDLE: begin
                    if (req_rise) begin
                        st_q <= ST_SET;
                        div_q <= 18'h00000;
                        ph_q <= 7'h00;
                    end
                end
                ST_SET: begin
                    if (ph_done) begin
                        bcd_digits_q <= word_bcd;
                        bcd_sign_q <= src_q[19];
                        bcd_oe_q <= 1'b1;
                        data_valid_q <= 1'b1;
                        st_q <= ST_VALID;
                        ph_q <= 7'h00;
                    end
                end
                ST_VALID: begin
                    if (ph_done) begin
                        data_valid_q <= 1'b0;
                        st_q <= ST_TAIL;
                        ph_q <= 7'h00;
                    end
                end
                ST_TAIL: begin
                    if (ph_done) begin
                        ph_q <= 7'h00;
                        if (req_s) begin
                            bcd_digits_q <= word_bcd;
                            bcd_sign_q <= src_q[19];
                            st_q <= ST_REARM;
                        end else begin
                            bcd_digits_q <= 20'h00000;
                            bcd_sign_q <= 1'b0;
                            bcd_oe_q <= 1'b0;
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_REARM: begin
                    if (ph_done) begin
                        data_valid_q <= 1'b1;
                        st_q <= ST_VALID;
                        ph_q <= 7'h00;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @* begin
        prdata = 32'h00000000;
        if (acc & ~pwrite) begin
            case (paddr)
                `A_CTRL: prdata = {26'h0000000, ctrl_q};
                `A_OFFSET: prdata = {12'h000, offset_q};
                `A_HI: prdata = {12'h000, hi_q};
                `A_LO: prdata = {12'h000, lo_q};
                `A_TEACH: prdata = {12'h000, teach_q};
                `A_STATUS: prdata = {24'h000000, st_q, track_q, armed_q,
                                     cmp_lo_q, cmp_pass_q, cmp_hi_q};
                `A_VALUE: prdata = {12'h000, held};
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule // bcd_result_port

/* bcd_reader_model.sv */
// Reader model that demands and captures BCD result words
`timescale 1ns/10ps
module bcd_reader_model #(
    parameter MS_CYCLES = 10
) (
    input wire clock,
    input wire rst,
    input wire want,
    input wire data_valid_q,
    input wire bcd_sign_q,
    input wire [19:0] bcd_digits_q,
    output reg read_req_in,
    output reg [20:0] word_q,
    output reg [7:0] words_q
);
    reg valid_prev_q;
    reg [31:0] gap_q;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            valid_prev_q <= 1'b0;
            gap_q <= 32'h0;
            read_req_in <= 1'b0;
            word_q <= 21'h0;
            words_q <= 8'h00;
        end else begin
            valid_prev_q <= data_valid_q;
            if (valid_prev_q && !data_valid_q) begin
                gap_q <= 20 * MS_CYCLES;
            end else if (gap_q != 0) begin
                gap_q <= gap_q - 1;
            end
            // Capture on the qualifier, never on our own demand
            if (data_valid_q && !valid_prev_q) begin
                word_q <= {bcd_sign_q, bcd_digits_q};
                words_q <= words_q + 8'h01;
            end
            read_req_in <= want && (read_req_in ||
                (gap_q == 0 && !(valid_prev_q && !data_valid_q)));
        end
    end
endmodule // bcd_reader_model

/* bcd_port_assertions.sv */
// Checker for the BCD result port
`timescale 1ns/10ps
`include "bcd_hold_defs.vh"
module bcd_port_checker #(
    parameter MS_CYCLES = 10
) (
    input wire clock,
    input wire rst,
    input wire read_req_in,
    input wire [19:0] bcd_digits_q,
    input wire bcd_sign_q,
    input wire bcd_oe_q,
    input wire data_valid_q,
    input wire cmp_hi_q,
    input wire cmp_pass_q,
    input wire cmp_lo_q
);
    // ****************************************
    // Cycle counters; a demand pin seen late makes the first word late too
    // ****************************************
    reg v_prev_q;
    reg r_prev_q;
    reg [31:0] vcnt_q;
    reg [31:0] tcnt_q;
    reg [31:0] pcnt_q;
    reg [31:0] rcnt_q;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            v_prev_q <= 1'b0;
            r_prev_q <= 1'b0;
            vcnt_q <= 32'h0;
            tcnt_q <= 32'h0;
            pcnt_q <= 32'h0;
            rcnt_q <= 32'h0;
        end else begin
            v_prev_q <= data_valid_q;
            r_prev_q <= read_req_in;
            vcnt_q <= data_valid_q ? vcnt_q + 1 : 32'h0;
            tcnt_q <= (bcd_oe_q && !data_valid_q) ? tcnt_q + 1 : 32'h0;
            pcnt_q <= (data_valid_q && !v_prev_q) ? 32'h1 : pcnt_q + 1;
            rcnt_q <= (read_req_in && !r_prev_q) ? 32'h1 : rcnt_q + 1;
        end
    end
    a_valid_width: assert property (@(posedge clock) disable iff (rst)
        $fell(data_valid_q) |-> vcnt_q == `T_VALID_MS * MS_CYCLES)
        else $error("qualifier width wrong");
    a_data_tail: assert property (@(posedge clock) disable iff (rst)
        $fell(bcd_oe_q) |-> tcnt_q == `T_TAIL_MS * MS_CYCLES)
        else $error("data release delay wrong");
    a_first_word: assert property (@(posedge clock) disable iff (rst)
        $rose(data_valid_q) && !$past(bcd_oe_q) |->
        rcnt_q >= `T_SET_MS * MS_CYCLES && rcnt_q <= `T_SET_MS * MS_CYCLES + 5)
        else $error("first word delay wrong");
    a_repeat_period: assert property (@(posedge clock) disable iff (rst)
        $rose(data_valid_q) && $past(bcd_oe_q) |-> pcnt_q == `T_PERIOD_MS * MS_CYCLES)
        else $error("repeat period wrong");
    a_data_with_qual: assert property (@(posedge clock) disable iff (rst)
        $rose(bcd_oe_q) |-> data_valid_q)
        else $error("data set without qualifier");
    a_qual_inside: assert property (@(posedge clock) disable iff (rst)
        data_valid_q |-> bcd_oe_q)
        else $error("qualifier without data");
    a_word_steady: assert property (@(posedge clock) disable iff (rst)
        data_valid_q && $past(data_valid_q) |-> $stable(bcd_digits_q) && $stable(bcd_sign_q))
        else $error("word changed while qualified");
    a_lines_released: assert property (@(posedge clock) disable iff (rst)
        !bcd_oe_q |-> bcd_digits_q == 20'h00000)
        else $error("digits not released");
    a_cmp_onehot: assert property (@(posedge clock) disable iff (rst)
        $onehot0({cmp_hi_q, cmp_pass_q, cmp_lo_q}))
        else $error("comparison outputs overlap");
endmodule // bcd_port_checker
bind bcd_result_port bcd_port_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock, .rst,
    .read_req_in, .bcd_digits_q, .bcd_sign_q, .bcd_oe_q, .data_valid_q, .cmp_hi_q,
    .cmp_pass_q, .cmp_lo_q);

/* tb_top.sv */
// Testbench for the BCD result port
`timescale 1ns/10ps
`include "bcd_hold_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    localparam MS = 10;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, meas_valid = 0;
    logic sample_in = 0, freeze_in = 0, clear_in = 0, want = 0, stdly = 0, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [19:0] meas_data = 20'h00000;
    wire [31:0] prdata;
    wire pready, pslverr, read_req_in, bcd_sign_q, bcd_oe_q, data_valid_q;
    wire cmp_hi_q, cmp_pass_q, cmp_lo_q;
    wire [19:0] bcd_digits_q;
    wire [20:0] word;
    wire [7:0] words;
    int num_errors = 0, compares = 0;
    bcd_result_port #(.MS_CYCLES(MS)) DUT (.clock, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas_data, .read_req_in,
        .sample_in, .freeze_in, .clear_in, .startup_delay_input(stdly), .bcd_digits_q,
        .bcd_sign_q, .bcd_oe_q, .data_valid_q, .cmp_hi_q, .cmp_pass_q, .cmp_lo_q);
    bcd_reader_model #(.MS_CYCLES(MS)) reader (.clock, .rst, .want, .data_valid_q,
        .bcd_sign_q, .bcd_digits_q, .read_req_in, .word_q(word), .words_q(words));
    initial begin
        forever #2 clock = ~clock;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic close_out();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic timeout();
        num_errors++;
        close_out();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16) timeout();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic meas(input logic [19:0] v);
        @(posedge clock);
        meas_valid <= 1'b1;
        meas_data <= v;
        @(posedge clock);
        meas_valid <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    task automatic value_is(input logic [19:0] e);
        apb(1'b0, `A_VALUE, 32'h0);
        `CHK(rdat[19:0], e)
    endtask
    task automatic pin(input bit clr);
        @(posedge clock);
        if (clr) clear_in <= 1'b1; else sample_in <= 1'b1;
        repeat (4) @(posedge clock);
        clear_in <= 1'b0;
        sample_in <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic wait_word(input logic [7:0] n);
        int i;
        for (i = 0; i < 2000 && words !== n; i++) @(posedge clock);
        if (words !== n) timeout();
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && bcd_oe_q !== 1'b0; i++) @(posedge clock);
        if (bcd_oe_q !== 1'b0) timeout();
    endtask
    task automatic cmp_is(input logic [19:0] v, input logic [2:0] e);
        meas(v);
        `CHK({cmp_hi_q, cmp_pass_q, cmp_lo_q}, e)
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, `A_HI, 32'h0);
        `CHK(rdat[19:0], `HI_RST)
        apb(1'b0, `A_LO, 32'h0);
        `CHK(rdat[19:0], `LO_RST)
        apb(1'b0, 8'h1C, 32'h0);
        `CHK({rerr, rdat}, {1'b1, 32'h0})
        `CHK(bcd_oe_q, 1'b0)
    endtask
    task automatic t_scale();
        apb(1'b1, `A_OFFSET, 32'h5);
        meas(20'h00064);
        value_is(20'h00069);
        apb(1'b1, `A_CTRL, 32'h10);
        meas(20'h00064);
        value_is(20'hFFFA1);
        apb(1'b1, `A_CTRL, 32'h20);
        meas(20'h00064);
        value_is(20'hFFF97);
        apb(1'b1, `A_OFFSET, 32'h0);
    endtask
    task automatic t_holds();
        logic [19:0] ex[3] = '{20'h00032, 20'h0000A, 20'h00028};
        logic [31:0] md[3] = '{32'h1, 32'h2, 32'h4};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `A_CTRL, md[i]);
            pin(1'b1);
            meas(20'h0000A);
            meas(20'h00032);
            meas(20'h0001E);
            value_is(ex[i]);
        end
        apb(1'b1, `A_CTRL, 32'h3);
        meas(20'h00007);
        pin(1'b0);
        meas(20'h00009);
        value_is(20'h00007);
        pin(1'b0);
        value_is(20'h00009);
    endtask
    task automatic t_cmp();
        apb(1'b1, `A_CTRL, 32'h0);
        apb(1'b1, `A_HI, 32'h64);
        apb(1'b1, `A_LO, 32'h0);
        cmp_is(20'h000C8, 3'b100);
        cmp_is(20'h00032, 3'b010);
        cmp_is(20'hFFFFB, 3'b001);
        apb(1'b1, `A_CTRL, 32'h8);
        cmp_is(20'h000C8, 3'b000);
        cmp_is(20'h00032, 3'b010);
        cmp_is(20'h000C8, 3'b100);
    endtask
    task automatic t_teach();
        apb(1'b1, `A_CTRL, 32'h0);
        meas(20'h0002A);
        apb(1'b1, `A_CTRL, 32'h40);
        apb(1'b0, `A_TEACH, 32'h0);
        `CHK(rdat[19:0], 20'h0002A)
        stdly <= 1'b1;
        repeat (3) @(posedge clock);
        meas(20'h00011);
        value_is(20'h0002A);
        stdly <= 1'b0;
        apb(1'b1, `A_CTRL, 32'h81);
        meas(20'h00005);
        value_is(20'h00005);
        apb(1'b0, `A_STATUS, 32'h0);
        `CHK(rdat[7:0], 8'h12)
    endtask
    task automatic t_transfers();
        apb(1'b1, `A_CTRL, 32'h0);
        meas(20'h004D2);
        want <= 1'b1;
        wait_word(8'd1);
        want <= 1'b0;
        `CHK(word, {1'b0, 20'h01234})
        wait_idle();
        `CHK(bcd_digits_q, 20'h00000)
        want <= 1'b1;
        wait_word(8'd2);
        meas(20'hFFFB3);
        wait_word(8'd3);
        `CHK(word, {1'b1, 20'h00077})
        freeze_in <= 1'b1;
        meas(20'h001F4);
        wait_word(8'd4);
        `CHK(word, {1'b1, 20'h00077})
        freeze_in <= 1'b0;
        want <= 1'b0;
        wait_idle();
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_scale();
        t_holds();
        t_cmp();
        t_teach();
        t_transfers();
        close_out();
    end
endmodule // tb_top
